// ==== hdl/dbu_regs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef DBU_REGS_SVH
`define DBU_REGS_SVH
`define DBU_OFF_RHR    8'h00
`define DBU_OFF_THR    8'h04
`define DBU_OFF_BRGR   8'h08
`define DBU_OFF_CIDR   8'h0C
`define DBU_OFF_ID_EXTENSION_VALUE   8'h10
`define DBU_OFF_FNR    8'h14
`define DBU_OFF_STAT   8'h18
`define DBU_OFF_MASK   8'h1C
`define DBU_OFF_CTRL   8'h20
`define DBU_ST_RECEIVER_READY_FLAG   0
`define DBU_ST_TRANSMITTER_READY_FLAG   1
`define DBU_ST_TXEMP   2
`define DBU_ST_FRAME   3
`define DBU_ST_OVRE    4
`define DBU_ST_W       5
`define DBU_CD_RST     16'h0000
`define DBU_OVS        4'hF
`endif

// ==== hdl/dbu_pkg.sv ====
// types shared by the debug serial unit
package dbu_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic       wr;
    logic       rd;
  } dbu_bus_req_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} dbu_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dbu_rx_st_t;
endpackage

// ==== hdl/dbu_uart.sv ====
// debug serial unit: data, baud, chip id and test reset registers
`timescale 1ns/1ps
`default_nettype none
`include "dbu_regs.svh"
module dbu_uart #(
  parameter logic [4:0]  VERSION  = 5'h01, // arbitrary value
  parameter logic [2:0]  CORE     = 3'h2,  // arbitrary value
  parameter logic [3:0]  NVPSZ    = 4'h9,
  parameter logic [3:0]  NVPSZ2   = 4'h0,
  parameter logic [3:0]  SRAMSZ   = 4'hA,
  parameter logic [7:0]  ARCHITECTURE_FAMILY_ID_ID  = 8'hA5, // arbitrary value
  parameter logic [2:0]  NVPTYPE  = 3'h2,
  parameter logic        HAS_EXT  = 1'b0,
  parameter logic [31:0] EXT_WORD = 32'h0000_0000 // arbitrary value
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // register bus
  input  wire dbu_pkg::dbu_bus_req_t bus_i,
  output logic [31:0]            rdata_o,
  // serial line
  input  wire logic              rxd_i,
  output logic                   txd_o,
  // test port reset
  input  wire logic              por_n_i,
  output logic                   tap_rst_n_o,
  // interrupt
  output logic                   irq_o
);
  import dbu_pkg::*;

  // size codes must not be one of the reserved codes
  initial begin
    if (NVPSZ == 4'h4 || NVPSZ == 4'h6 || NVPSZ == 4'h8 ||
        NVPSZ == 4'hB || NVPSZ == 4'hD || NVPSZ == 4'hF)
      $error("reserved program memory size code");
    if (SRAMSZ == 4'h0)
      $error("reserved sram size code");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [15:0] cd_r;
  logic        fnr_r;
  logic [7:0]  rhr_r;
  logic [7:0]  thr_r;
  logic        receiver_ready_flag_r;
  logic        transmitter_ready_flag_r;
  logic        rx_en_r;
  logic        tx_en_r;
  logic [`DBU_ST_W-1:0] stat_r;
  logic [`DBU_ST_W-1:0] mask_r;
  logic        wr_thr;
  logic        rd_rhr;
  logic        rx_done;
  logic        rx_ferr;
  logic        tx_load;
  logic        tx_busy;
  logic [7:0]  rx_char;

  assign wr_thr = bus_i.wr && hit(bus_i.addr, `DBU_OFF_THR);
  assign rd_rhr = bus_i.rd && hit(bus_i.addr, `DBU_OFF_RHR);

  // configuration registers; only defined field bits are kept
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cd_r    <= `DBU_CD_RST;
      fnr_r   <= 1'b0;
      mask_r  <= '0;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else if (bus_i.wr) begin
      if (hit(bus_i.addr, `DBU_OFF_BRGR)) cd_r <= bus_i.wdata[15:0];
      if (hit(bus_i.addr, `DBU_OFF_FNR))  fnr_r <= bus_i.wdata[0];
      if (hit(bus_i.addr, `DBU_OFF_MASK)) mask_r <= bus_i.wdata[`DBU_ST_W-1:0];
      if (hit(bus_i.addr, `DBU_OFF_CTRL)) begin
        rx_en_r <= bus_i.wdata[0];
        tx_en_r <= bus_i.wdata[1];
      end
    end
  end

  // test port reset: forced low or follows power-on reset
  // force select
  assign tap_rst_n_o = fnr_r ? 1'b0 : por_n_i;

  // baud generator: produces a sixteen-times oversample tick
  logic [15:0] div_r;
  logic        tick16;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 16'h0000;
    end else if (cd_r == 16'h0000 || cd_r == 16'h0001 || div_r >= cd_r - 16'h0001) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  // divisor one means the bit clock itself is the master clock
  logic        cd_one;
  logic        bit_tick_d;
  assign cd_one = (cd_r == 16'h0001);
  assign tick16 = (cd_r > 16'h0001) && (div_r == cd_r - 16'h0001);

  // rx line synchroniser
  logic rx_s1_r;
  logic rx_s2_r;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd_i;
      rx_s2_r <= rx_s1_r;
    end
  end

  // transmit bit tick: every sixteenth oversample, or every clock
  logic [3:0] tx_ph_r;
  logic       tx_tick;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) tx_ph_r <= 4'h0;
    else if (tick16) tx_ph_r <= tx_ph_r + 4'h1;
  end
  assign bit_tick_d = tick16 && (tx_ph_r == `DBU_OVS);
  assign tx_tick = cd_one | bit_tick_d;

  // transmitter
  dbu_tx_st_t  tx_st_r;
  logic [7:0]  tx_sh_r;
  logic [2:0]  tx_cnt_r;
  // next char loaded when shifter free
  assign tx_busy = (tx_st_r != TX_IDLE);
  assign tx_load = tx_en_r && !transmitter_ready_flag_r && !tx_busy && tx_tick;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_r  <= TX_IDLE;
      tx_sh_r  <= 8'h00;
      tx_cnt_r <= 3'h0;
      txd_o    <= 1'b1;
    end else if (tx_tick) begin
      case (tx_st_r)
        TX_IDLE: if (tx_load) begin
          tx_sh_r <= thr_r;
          tx_st_r <= TX_START;
          txd_o   <= 1'b0;
        end
        TX_START: begin
          txd_o    <= tx_sh_r[0];
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_cnt_r <= 3'h0;
          tx_st_r  <= TX_DATA;
        end
        TX_DATA: if (tx_cnt_r == 3'h7) begin
          txd_o   <= 1'b1;
          tx_st_r <= TX_STOP;
        end else begin
          txd_o    <= tx_sh_r[0];
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_cnt_r <= tx_cnt_r + 3'h1;
        end
        TX_STOP: tx_st_r <= TX_IDLE;
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // transmit holding register and its ready flag
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thr_r   <= 8'h00;
      transmitter_ready_flag_r <= 1'b1;
    end else if (wr_thr) begin
      thr_r   <= bus_i.wdata[7:0];
      transmitter_ready_flag_r <= 1'b0;
    end else if (tx_load) begin
      transmitter_ready_flag_r <= 1'b1;
    end
  end

  // receiver: samples mid-bit on the oversample ticks
  dbu_rx_st_t  rx_st_r;
  logic [3:0]  rx_ph_r;
  logic [2:0]  rx_cnt_r;
  logic [7:0]  rx_sh_r;
  logic        rx_tick;
  // with divisor one there is no oversample, so each clock is a sample
  assign rx_tick = cd_one | tick16;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_r  <= RX_IDLE;
      rx_ph_r  <= 4'h0;
      rx_cnt_r <= 3'h0;
      rx_sh_r  <= 8'h00;
    end else if (!rx_en_r) begin
      rx_st_r <= RX_IDLE;
    end else if (rx_tick) begin
      rx_ph_r <= cd_one ? 4'h0 : rx_ph_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: if (!rx_s2_r) begin
          rx_st_r <= RX_START;
          rx_ph_r <= 4'h0;
        end
        RX_START: if (cd_one || rx_ph_r == 4'h7) begin
          rx_ph_r  <= 4'h0;
          rx_cnt_r <= 3'h0;
          rx_st_r  <= rx_s2_r ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (cd_one || rx_ph_r == `DBU_OVS) begin
          rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
          rx_cnt_r <= rx_cnt_r + 3'h1;
          if (rx_cnt_r == 3'h7) rx_st_r <= RX_STOP;
        end
        RX_STOP: if (cd_one || rx_ph_r == `DBU_OVS) rx_st_r <= RX_IDLE;
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end
  assign rx_done = rx_en_r && rx_tick && (rx_st_r == RX_STOP) &&
                   (cd_one || rx_ph_r == `DBU_OVS);
  assign rx_ferr = rx_done && !rx_s2_r;
  assign rx_char = rx_sh_r;

  // receive holding register and ready flag; a new char beats the read
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rhr_r   <= 8'h00;
      receiver_ready_flag_r <= 1'b0;
    end else if (rx_done) begin
      rhr_r   <= rx_char;
      receiver_ready_flag_r <= 1'b1;
    end else if (rd_rhr || !rx_en_r) begin
      receiver_ready_flag_r <= 1'b0;
    end
  end

  // sticky status; hardware set wins over write-one-to-clear
  logic [`DBU_ST_W-1:0] ev;
  logic [`DBU_ST_W-1:0] clr;
  assign ev = {rx_done && receiver_ready_flag_r && !rd_rhr, rx_ferr,
               tx_en_r && transmitter_ready_flag_r && !tx_busy, tx_load, rx_done};
  assign clr = (bus_i.wr && hit(bus_i.addr, `DBU_OFF_STAT)) ?
               bus_i.wdata[`DBU_ST_W-1:0] : '0;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) stat_r <= '0;
    else stat_r <= (stat_r & ~clr) | ev;
  end
  assign irq_o = |(stat_r & mask_r);

  // chip identification word
  logic [31:0] cidr;
  assign cidr = {HAS_EXT, NVPTYPE, ARCHITECTURE_FAMILY_ID_ID, SRAMSZ, NVPSZ2, NVPSZ,
                 CORE, VERSION};

  // read mux, one cycle latency; unmapped reads return zero
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        `DBU_OFF_RHR:  rdata_o <= {24'h000000, rhr_r};
        `DBU_OFF_BRGR: rdata_o <= {16'h0000, cd_r};
        `DBU_OFF_CIDR: rdata_o <= cidr;
        `DBU_OFF_ID_EXTENSION_VALUE: rdata_o <= HAS_EXT ? EXT_WORD : 32'h0000_0000;
        `DBU_OFF_FNR:  rdata_o <= {31'h0, fnr_r};
        `DBU_OFF_STAT: rdata_o <= {27'h0, stat_r};
        `DBU_OFF_MASK: rdata_o <= {27'h0, mask_r};
        `DBU_OFF_CTRL: rdata_o <= {27'h0, !tx_busy && transmitter_ready_flag_r, transmitter_ready_flag_r,
                                   receiver_ready_flag_r, tx_en_r, rx_en_r};
        default:       rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // checks
  tap_force_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    fnr_r |-> !tap_rst_n_o) else $error("tap reset not held low");
  tap_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !fnr_r |-> tap_rst_n_o == por_n_i) else $error("tap reset not por");
  rx_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (rd_rhr && !rx_done) |=> !receiver_ready_flag_r) else $error("rx ready kept");
  rx_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rx_done |=> receiver_ready_flag_r && rhr_r == $past(rx_char)) else $error("rx char");
  tx_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    wr_thr |=> !transmitter_ready_flag_r && thr_r == $past(bus_i.wdata[7:0]))
    else $error("tx ready not dropped");
  // a write in the load cycle wins the ready flag, so it is left out here
  tx_load_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (tx_load && !wr_thr) |=> transmitter_ready_flag_r && tx_st_r == TX_START && !txd_o)
    else $error("tx load");
  baud_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (cd_r == 16'h0000) |-> !tx_tick && !rx_tick)
    else $error("baud not off");
  id_extension_value_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_ID_EXTENSION_VALUE && !HAS_EXT) |=> rdata_o == 0)
    else $error("extension not zero");
  cidr_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_CIDR) |=>
    rdata_o[31] == HAS_EXT && rdata_o[7:5] == CORE && rdata_o[4:0] == VERSION)
    else $error("id word");
  rhr_resv_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_RHR) |=> rdata_o[31:8] == 0)
    else $error("reserved bits");
  // line stays at its idle level whenever no frame is under way
  txd_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (tx_st_r == TX_IDLE) |-> txd_o)
    else $error("tx line not idle");
  // disabling the receiver drops its ready flag
  rx_dis_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !rx_en_r |=> !receiver_ready_flag_r)
    else $error("rx ready kept while off");
  // a finished character always leaves its sticky bit set
  stat_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rx_done |=> stat_r[0])
    else $error("rx status not set");
  // read data stands one cycle only, zero otherwise
  rd_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !bus_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero");
  // divisor read back with its upper half clear
  brgr_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_BRGR) |=>
    rdata_o == {16'h0000, $past(cd_r)})
    else $error("divisor read");
  // middle id fields come straight from the parameters
  cidr_mid_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_CIDR) |=>
    rdata_o[30:8] == {NVPTYPE, ARCHITECTURE_FAMILY_ID_ID, SRAMSZ, NVPSZ2, NVPSZ})
    else $error("id fields");
  // only the force bit of its register is ever visible
  fnr_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (bus_i.rd && bus_i.addr == `DBU_OFF_FNR) |=> rdata_o[31:1] == 0)
    else $error("force reserved bits");
  // the oversample tick never fires in two cycles running
  tick_gap_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tick16 |=> !tick16)
    else $error("oversample tick too fast");
  // clearing a status bit that is not being set leaves it clear
  stat_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (clr[0] && !ev[0]) |=> !stat_r[0])
    else $error("status not cleared");
  clr_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    clr[0] && stat_r[0]);
  rx_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) rx_done);
  tx_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) tx_load);
  irq_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) irq_o);
endmodule // dbu_uart
`default_nettype wire

// ==== bench/dbu_term.sv ====
// serial terminal model that sends and captures 8N1 characters
`timescale 1ns/1ps
`default_nettype none
module dbu_term #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input  wire logic sys_clk_i,
  // serial line
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  // line idles high outside frames
  initial line_o = 1'b1;
  // one frame, lsb first; caller enters just after a clock edge
  task automatic send(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge sys_clk_i);
    for (int i = 0; i < 9; i++) begin
      line_o <= (i == 8) ? 1'b1 : b[i];
      repeat (BIT_CLKS) @(posedge sys_clk_i);
    end
  endtask
  // sample mid-cell so the sender's output delay does not matter
  initial begin
    forever begin
      @(negedge line_i);
      repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge sys_clk_i);
        sh[i] = line_i;
      end
      repeat (BIT_CLKS) @(posedge sys_clk_i);
      got_q.push_back(sh);
    end
  end
endmodule // dbu_term
`default_nettype wire

// ==== bench/test_dbu_uart.sv ====
// self-checking bench for the debug serial unit registers
`timescale 1ns/1ps
`default_nettype none
`include "dbu_regs.svh"
module test_dbu_uart;
  import dbu_pkg::*;
  // id fields chosen here; values are arbitrary
  localparam logic [31:0] ID_EXP =
    {1'b0, 3'h3, 8'h5C, 4'hA, 4'h0, 4'hC, 3'h5, 5'h0B};
  logic         sys_clk_i, rstn_i, por_n_i;
  dbu_bus_req_t bus;
  logic [31:0]  rdata_o, got;
  logic         txd_o, rxd_i, tap_rst_n_o, irq_o;
  int           mismatches, num_checks;

  dbu_uart #(.VERSION(5'h0B), .CORE(3'h5), .NVPSZ(4'hC),
    .ARCHITECTURE_FAMILY_ID_ID(8'h5C), .NVPTYPE(3'h3)) u_dbu_uart (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus),
    .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .por_n_i(por_n_i),
    .tap_rst_n_o(tap_rst_n_o), .irq_o(irq_o));
  // divisor 2 gives 32 clocks per bit
  dbu_term u_dbu_term (
    .sys_clk_i(sys_clk_i), .line_i(txd_o), .line_o(rxd_i));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk_i);
    bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    bus <= '0;
    #1 got = rdata_o;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_ident;
    rd(`DBU_OFF_CIDR);
    chk(got, ID_EXP);
    rd(`DBU_OFF_ID_EXTENSION_VALUE);
    chk(got, 32'h0);
    rd(8'h40);
    chk(got, 32'h0);
  endtask
  task automatic t_regs;
    wr(`DBU_OFF_BRGR, 32'hFFFF_0002);
    rd(`DBU_OFF_BRGR);
    chk(got, 32'h0000_0002);
    wr(`DBU_OFF_FNR, 32'hFFFF_FFFF);
    rd(`DBU_OFF_FNR);
    chk(got, 32'h0000_0001);
    chk({31'h0, tap_rst_n_o}, 32'h0);
    wr(`DBU_OFF_FNR, 32'h0);
    tick(1);
    chk({31'h0, tap_rst_n_o}, 32'h1);
    por_n_i <= 1'b0;
    tick(1);
    chk({31'h0, tap_rst_n_o}, 32'h0);
    por_n_i <= 1'b1;
  endtask
  task automatic t_tx;
    int n;
    wr(`DBU_OFF_CTRL, 32'h3);
    wr(`DBU_OFF_THR, 32'h0000_01A5);
    // wait for the first char to move into the shifter before queueing
    n = 0;
    do begin
      rd(`DBU_OFF_CTRL);
      n++;
    end while ((got & 32'h8) == 32'h0 && n < 100);
    chk(got & 32'h8, 32'h8);
    wr(`DBU_OFF_THR, 32'h0000_003C);
    rd(`DBU_OFF_CTRL);
    chk(got & 32'h8, 32'h0);
    n = 0;
    while (u_dbu_term.got_q.size() < 2 && n < 2000) begin
      tick(1);
      n++;
    end
    chk({31'h0, n < 2000}, 32'h1);
    chk({24'h0, u_dbu_term.got_q[0]}, 32'hA5);
    chk({24'h0, u_dbu_term.got_q[1]}, 32'h3C);
    rd(`DBU_OFF_CTRL);
    chk(got & 32'h8, 32'h8);
  endtask
  task automatic t_rx;
    int n;
    wr(`DBU_OFF_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq_o}, 32'h0);
    u_dbu_term.send(8'h5A);
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk({31'h0, irq_o}, 32'h1);
    rd(`DBU_OFF_RHR);
    chk(got, 32'h5A);
    rd(`DBU_OFF_CTRL);
    chk(got & 32'h4, 32'h0);
    wr(`DBU_OFF_STAT, 32'h1);
    tick(2);
    chk({31'h0, irq_o}, 32'h0);
    // masked event: sticky bit sets but the line stays low
    wr(`DBU_OFF_MASK, 32'h0);
    u_dbu_term.send(8'hC3);
    tick(64);
    chk({31'h0, irq_o}, 32'h0);
    rd(`DBU_OFF_STAT);
    chk(got & 32'h1, 32'h1);
    rd(`DBU_OFF_RHR);
    chk(got, 32'hC3);
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    rstn_i = 1'b0;
    por_n_i = 1'b1;
    bus = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_ident;
    t_regs;
    t_tx;
    t_rx;
    end_of_test;
  end
  // watchdog: all scenarios need under 3000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    end_of_test;
  end
endmodule // test_dbu_uart
`default_nettype wire
